//--- hdl/ccp_pkg.sv
// Constants, register map and field types of the compare/PWM channel
package ccp_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the Wishbone bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_MATCH = 8'h04;
   localparam logic [7:0] ADR_PERIOD = 8'h08;
   localparam logic [7:0] ADR_TIMER = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_COUNT = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ALIGN_BIT = 4;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_IRQ_EN_BIT = 8;
   localparam int CTRL_ADC_SEL_BIT = 9;
   localparam int TIMER_ON_BIT = 0;
   localparam int TIMER_PRESC_LSB = 1;
   localparam int STAT_MATCH_BIT = 0;
   localparam int STAT_PERIOD_BIT = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] MATCH_RST = 16'h0000;
   localparam logic [7:0] PERIOD_RST = 8'hff;

   // ----------------------------------------------------------------
   // Mode select encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE_CLR = 4'h1;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_SET = 4'h8;
   localparam logic [3:0] MODE_CLEAR = 4'h9;
   localparam logic [3:0] MODE_PULSE = 4'ha;
   localparam logic [3:0] MODE_PULSE_CLR = 4'hb;
   localparam logic [3:0] MODE_PWM = 4'hf;

   // Period prescale select: 00 = 1:1, 01 = 1:4, 10 = 1:16, 11 = 1:64
   localparam int PRESC_W = 8;

   typedef struct packed {
      logic adc_sel;
      logic irq_en;
      logic enable;
      logic align;
      logic [3:0] mode;
   } ccp_ctrl_t;

   typedef struct packed {
      logic on;
      logic [1:0] presc;
   } ccp_timer_t;

endpackage : ccp_pkg

//--- hdl/ccp_compare_pwm.sv
// Compare and standard PWM channel with a classic Wishbone register slave
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module ccp_compare_pwm #(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] compare_counter_i,
   input wire logic compare_sync_i,
   input wire logic compare_clock_alive_i,
   input wire logic sleep_i,
   output logic ccp_out_o,
   output logic adc_trigger_o,
   output logic compare_timer_clear_o,
   output logic wake_o
);

   localparam int PRESC_LAST_W = ccp_pkg::PRESC_W;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0])
      begin
         r[7:0] = d[7:0];
      end
      if (sel[1])
      begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : merge16

   function automatic logic [PRESC_LAST_W-1:0] presc_last(input logic [1:0] sel);
      case (sel)
         2'b00: presc_last = PRESC_LAST_W'(3);
         2'b01: presc_last = PRESC_LAST_W'(15);
         2'b10: presc_last = PRESC_LAST_W'(63);
         default: presc_last = PRESC_LAST_W'(255);
      endcase
   endfunction : presc_last

   // Two low time-base bits: system clock phase at 1:1, prescaler top bits otherwise
   function automatic logic [1:0] low_bits(input logic [1:0] sel,
                                           input logic [PRESC_LAST_W-1:0] cnt);
      case (sel)
         2'b00: low_bits = cnt[1:0];
         2'b01: low_bits = cnt[3:2];
         2'b10: low_bits = cnt[5:4];
         default: low_bits = cnt[7:6];
      endcase
   endfunction : low_bits

   function automatic logic [9:0] duty_of(input logic [15:0] pair, input logic align);
      duty_of = align ? pair[15:6] : pair[9:0];
   endfunction : duty_of

   function automatic logic is_compare(input logic [3:0] m);
      is_compare = (m == ccp_pkg::MODE_TOGGLE_CLR) || (m == ccp_pkg::MODE_TOGGLE) ||
                   (m == ccp_pkg::MODE_SET) || (m == ccp_pkg::MODE_CLEAR) ||
                   (m == ccp_pkg::MODE_PULSE) || (m == ccp_pkg::MODE_PULSE_CLR);
   endfunction : is_compare

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   ccp_pkg::ccp_ctrl_t ctrl_reg;
   ccp_pkg::ccp_timer_t timer_reg;
   logic [15:0] match_reg;
   logic [7:0] period_limit_reg;
   logic [7:0] period_counter_reg;
   logic [PRESC_LAST_W-1:0] presc_reg;
   logic [9:0] duty_buf_reg;
   logic out_reg;
   logic pulse_reg;
   logic match_flag_reg;
   logic period_flag_reg;
   logic eq_reg;
   logic clr_pend_reg;
   logic adc_reg;
   logic clr_reg;
   logic wake_reg;
   logic ack_reg;
   logic [31:0] dat_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic bus_req;
   logic wr_en;
   logic [7:0] adr;
   logic ctrl_wr;
   logic ctrl_zero_wr;
   logic status_wr;
   logic [15:0] ctrl_word;
   logic [15:0] ctrl_new;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_en = bus_req && wb_we_i;
   assign adr = 8'(wb_adr_i);
   assign ctrl_wr = wr_en && (adr == ccp_pkg::ADR_CTRL);
   assign status_wr = wr_en && (adr == ccp_pkg::ADR_STATUS);
   assign ctrl_word = {6'h00, ctrl_reg.adc_sel, ctrl_reg.irq_en, ctrl_reg.enable, 1'b0,
                       out_reg, ctrl_reg.align, ctrl_reg.mode};
   assign ctrl_new = merge16(ctrl_word, wb_dat_i, wb_sel_i);
   // Clearing the control byte resets the channel
   assign ctrl_zero_wr = ctrl_wr && wb_sel_i[0] && (wb_dat_i[7:0] == 8'h00);

   // ----------------------------------------------------------------
   // Period time base
   // ----------------------------------------------------------------
   logic run;
   logic presc_end;
   logic wrap;
   logic [7:0] count_next;
   logic [PRESC_LAST_W-1:0] presc_next;
   logic [9:0] tb_next;
   logic [9:0] duty_new;
   logic pwm_on;
   logic duty_hit;

   assign run = timer_reg.on && !sleep_i;
   assign presc_end = (presc_reg == presc_last(timer_reg.presc));
   // Postscaling is deliberately absent: the wrap happens every period
   assign wrap = run && presc_end && (period_counter_reg == period_limit_reg);
   assign pwm_on = ctrl_reg.enable && (ctrl_reg.mode == ccp_pkg::MODE_PWM);
   assign duty_new = duty_of(match_reg, ctrl_reg.align);

   always_comb
   begin
      count_next = period_counter_reg;
      presc_next = presc_reg;
      if (run)
      begin
         if (presc_end)
         begin
            presc_next = '0;
            count_next = wrap ? 8'h00 : 8'(period_counter_reg + 8'h01);
         end
         else
         begin
            presc_next = PRESC_LAST_W'(presc_reg + 1'b1);
         end
      end
      tb_next = {count_next, low_bits(timer_reg.presc, presc_next)};
   end

   logic [9:0] tb_cur;

   // One hit per step: at slow prescales the time base rests on a value for several clocks
   assign tb_cur = {period_counter_reg, low_bits(timer_reg.presc, presc_reg)};
   // Compare against the next time base so high time is exactly duty steps
   assign duty_hit = pwm_on && run && !wrap && (tb_next == duty_buf_reg) &&
                     (tb_cur != duty_buf_reg);

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         period_counter_reg <= 8'h00;
         presc_reg <= '0;
      end
      else
      begin
         period_counter_reg <= count_next;
         presc_reg <= presc_next;
      end
   end

   // Duty buffer loads only at the period wrap and clears on a zero control byte, so mid-period match writes cannot glitch
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         duty_buf_reg <= 10'h000;
      end
      else if (ctrl_zero_wr)
      begin
         duty_buf_reg <= 10'h000;
      end
      else if (wrap)
      begin
         duty_buf_reg <= duty_new;
      end
   end

   // ----------------------------------------------------------------
   // Compare path
   // ----------------------------------------------------------------
   logic cmp_ok;
   logic cmp_eq;
   logic cmp_hit;
   logic clears_timer;

   // Asynchronous timer values may be mid-ripple, so they are not trusted
   assign cmp_ok = ctrl_reg.enable && is_compare(ctrl_reg.mode) && compare_sync_i &&
                   (!sleep_i || compare_clock_alive_i);
   assign cmp_eq = cmp_ok && (compare_counter_i == match_reg);
   // Act once per match; the counter may sit on the value for many clocks
   assign cmp_hit = cmp_eq && !eq_reg;
   assign clears_timer = (ctrl_reg.mode == ccp_pkg::MODE_TOGGLE_CLR) ||
                         (ctrl_reg.mode == ccp_pkg::MODE_PULSE_CLR);

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         eq_reg <= 1'b0;
         clr_pend_reg <= 1'b0;
         clr_reg <= 1'b0;
         adc_reg <= 1'b0;
      end
      else
      begin
         eq_reg <= cmp_eq;
         clr_pend_reg <= cmp_hit && clears_timer;
         // Timer clear follows the trigger by one edge and needs the match still there
         clr_reg <= clr_pend_reg && cmp_eq;
         adc_reg <= (cmp_hit || duty_hit) && ctrl_reg.adc_sel;
      end
   end

   // ----------------------------------------------------------------
   // Output latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         out_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else if (ctrl_zero_wr || !ctrl_reg.enable || ctrl_reg.mode == ccp_pkg::MODE_OFF)
      begin
         out_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else if (pwm_on)
      begin
         pulse_reg <= 1'b0;
         if (wrap)
         begin
            out_reg <= (duty_new != 10'h000);
         end
         else if (duty_hit)
         begin
            out_reg <= 1'b0;
         end
         // Duty beyond the period never matches, so the pin keeps its level
      end
      else if (pulse_reg)
      begin
         out_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else if (cmp_hit)
      begin
         case (ctrl_reg.mode)
            ccp_pkg::MODE_TOGGLE_CLR, ccp_pkg::MODE_TOGGLE: out_reg <= !out_reg;
            ccp_pkg::MODE_SET: out_reg <= 1'b1;
            ccp_pkg::MODE_CLEAR: out_reg <= 1'b0;
            default:
            begin
               out_reg <= 1'b1;
               pulse_reg <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flags and wake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         match_flag_reg <= 1'b0;
         period_flag_reg <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         // A set in the same cycle as a write-one-clear wins
         if (cmp_hit || duty_hit)
         begin
            match_flag_reg <= 1'b1;
         end
         else if (status_wr && wb_sel_i[0] && wb_dat_i[ccp_pkg::STAT_MATCH_BIT])
         begin
            match_flag_reg <= 1'b0;
         end
         if (wrap)
         begin
            period_flag_reg <= 1'b1;
         end
         else if (status_wr && wb_sel_i[0] && wb_dat_i[ccp_pkg::STAT_PERIOD_BIT])
         begin
            period_flag_reg <= 1'b0;
         end
         wake_reg <= sleep_i && ctrl_reg.irq_en && match_flag_reg;
      end
   end

   // ----------------------------------------------------------------
   // Software-written registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_reg <= '0;
         timer_reg <= '0;
         match_reg <= ccp_pkg::MATCH_RST;
         period_limit_reg <= ccp_pkg::PERIOD_RST;
      end
      else if (wr_en)
      begin
         if (adr == ccp_pkg::ADR_CTRL)
         begin
            ctrl_reg.mode <= ctrl_new[3:0];
            ctrl_reg.align <= ctrl_new[ccp_pkg::CTRL_ALIGN_BIT];
            ctrl_reg.enable <= ctrl_new[ccp_pkg::CTRL_EN_BIT];
            ctrl_reg.irq_en <= ctrl_new[ccp_pkg::CTRL_IRQ_EN_BIT];
            ctrl_reg.adc_sel <= ctrl_new[ccp_pkg::CTRL_ADC_SEL_BIT];
         end
         else if (adr == ccp_pkg::ADR_MATCH)
         begin
            match_reg <= merge16(match_reg, wb_dat_i, wb_sel_i);
         end
         else if (adr == ccp_pkg::ADR_PERIOD && wb_sel_i[0])
         begin
            period_limit_reg <= wb_dat_i[7:0];
         end
         else if (adr == ccp_pkg::ADR_TIMER && wb_sel_i[0])
         begin
            timer_reg.on <= wb_dat_i[ccp_pkg::TIMER_ON_BIT];
            timer_reg.presc <= wb_dat_i[ccp_pkg::TIMER_PRESC_LSB +: 2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Wishbone answer: one wait state, unmapped reads return zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= bus_req;
         if (bus_req && !wb_we_i)
         begin
            if (adr == ccp_pkg::ADR_CTRL)
            begin
               dat_reg <= {16'h0000, ctrl_word};
            end
            else if (adr == ccp_pkg::ADR_MATCH)
            begin
               dat_reg <= {16'h0000, match_reg};
            end
            else if (adr == ccp_pkg::ADR_PERIOD)
            begin
               dat_reg <= {24'h000000, period_limit_reg};
            end
            else if (adr == ccp_pkg::ADR_TIMER)
            begin
               dat_reg <= {29'h00000000, timer_reg.presc, timer_reg.on};
            end
            else if (adr == ccp_pkg::ADR_STATUS)
            begin
               dat_reg <= {30'h00000000, period_flag_reg, match_flag_reg};
            end
            else if (adr == ccp_pkg::ADR_COUNT)
            begin
               dat_reg <= {6'h00, duty_buf_reg, 8'h00, period_counter_reg};
            end
            else
            begin
               dat_reg <= 32'h0000_0000;
            end
         end
         else
         begin
            dat_reg <= 32'h0000_0000;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign ccp_out_o = out_reg;
   assign adc_trigger_o = adc_reg;
   assign compare_timer_clear_o = clr_reg;
   assign wake_o = wake_reg;

endmodule : ccp_compare_pwm

//--- sim/ccp_properties.sv
// Port checker for the compare/PWM channel, bound into the design
`timescale 1ns/10ps
module ccp_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic compare_clock_alive_i,
   input wire logic sleep_i,
   input wire logic ccp_out_o,
   input wire logic adc_trigger_o,
   input wire logic compare_timer_clear_o,
   input wire logic wake_o
);
   logic req;
   assign req = wb_cyc_i && wb_stb_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
      else $error("acknowledge without request");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside acknowledge");
   a_trig_single: assert property (adc_trigger_o |=> !adc_trigger_o)
      else $error("conversion trigger longer than one cycle");
   a_clear_single: assert property (compare_timer_clear_o |=> !compare_timer_clear_o)
      else $error("timer clear longer than one cycle");
   a_wake_sleep: assert property (!sleep_i |=> !wake_o)
      else $error("wake while awake");
   a_sleep_hold: assert property (sleep_i && !compare_clock_alive_i && !req |=>
      $stable(ccp_out_o))
      else $error("output moved in sleep");
   cover property (adc_trigger_o);
   cover property (compare_timer_clear_o);
   cover property (sleep_i && wake_o);
endmodule : ccp_checker

bind ccp_compare_pwm ccp_checker chk_u (.clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
   .wb_ack_o, .compare_clock_alive_i, .sleep_i, .ccp_out_o, .adc_trigger_o,
   .compare_timer_clear_o, .wake_o);

//--- sim/ccp_timer_model.sv
// Compare timer model: steps once every four system clocks
`timescale 1ns/10ps
module ccp_timer_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic restart_i,
   input wire logic clear_i,
   output logic [15:0] count_o
);
   logic [1:0] div_reg;
   // Instruction-clock rate, never the raw system clock
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_reg <= 2'h0;
         count_o <= 16'h0;
      end
      else if (restart_i || clear_i)
      begin
         div_reg <= 2'h0;
         count_o <= 16'h0;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'h3)
            count_o <= count_o + 16'h1;
      end
   end
endmodule : ccp_timer_model

//--- sim/tb_top.sv
// Self-checking bench for the compare/PWM channel
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, restart = 1'b0;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, c0;
   logic wb_ack_o, ccp_out_o, adc_trigger_o, compare_timer_clear_o, wake_o, v;
   logic compare_sync_i = 1'b1, compare_clock_alive_i = 1'b0, sleep_i = 1'b0;
   logic [15:0] compare_counter_i;
   int miscompares = 0, n_checks = 0, n, hi, per, k;
   typedef struct {logic we; logic [7:0] a; logic [31:0] d;} ccp_row_t;
   typedef struct {logic [7:0] p; logic [1:0] ps; logic al; logic [15:0] m;
      int hi; int per;} ccp_pwm_t;
   ccp_row_t rows [15] = '{'{0, 8'h00, 32'h0}, '{0, 8'h04, 32'h0}, '{0, 8'h08, 32'hff},
      '{0, 8'h0c, 32'h0}, '{0, 8'h10, 32'h0}, '{0, 8'h14, 32'h0}, '{1, 8'h04, 32'hbeef},
      '{0, 8'h04, 32'hbeef}, '{1, 8'h00, 32'h20}, '{0, 8'h00, 32'h0}, '{1, 8'h18, 32'h5a},
      '{0, 8'h18, 32'h0}, '{1, 8'h0c, 32'h6}, '{0, 8'h0c, 32'h6}, '{1, 8'h0c, 32'h0}};
   ccp_pwm_t pwm [6] = '{'{8'h00, 2'h0, 1'b0, 16'hfc02, 2, 4},
      '{8'h00, 2'h2, 1'b0, 16'h0001, 16, 64}, '{8'h00, 2'h3, 1'b0, 16'h0003, 192, 256},
      '{8'h01, 2'h0, 1'b1, 16'h00bf, 2, 8}, '{8'h03, 2'h1, 1'b0, 16'h0005, 20, 64},
      '{8'hff, 2'h0, 1'b0, 16'h03ff, 1023, 1024}};
   logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
   // Bits are sync, sleep, alive
   logic [2:0] inh [3] = '{3'b001, 3'b110, 3'b111};

   // Pin routing and direction sit outside the block; the latch is watched directly
   ccp_compare_pwm dut_u (.clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .compare_counter_i, .compare_sync_i,
      .compare_clock_alive_i, .sleep_i, .ccp_out_o, .adc_trigger_o,
      .compare_timer_clear_o, .wake_o);
   ccp_timer_model tmr_u (.clk_i, .reset_n_i, .restart_i(restart),
      .clear_i(compare_timer_clear_o), .count_o(compare_counter_i));

   always #10 clk_i = ~clk_i;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   // Timer held at zero while the mode changes, so no stray match slips in
   task automatic arm(input logic [31:0] ctrl);
      restart <= 1'b1;
      wb(1'b1, ccp_pkg::ADR_CTRL, 32'h0);
      wb(1'b1, ccp_pkg::ADR_STATUS, 32'h3);
      wb(1'b1, ccp_pkg::ADR_CTRL, ctrl);
      restart <= 1'b0;
   endtask : arm

   task automatic count_high(output int c);
      c = 0;
      repeat (8)
      begin
         @(posedge clk_i);
         c += int'(ccp_out_o === 1'b1);
      end
   endtask : count_high

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (30000) @(posedge clk_i);
      miscompares++;
      final_report();
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      check(32'({ccp_out_o, adc_trigger_o, compare_timer_clear_o, wake_o}), 32'h0);
      foreach (rows[i])
      begin
         wb(rows[i].we, rows[i].a, rows[i].d);
         if (!rows[i].we)
            check(q, rows[i].d);
      end
      $display("register rows done");
      wb(1'b1, ccp_pkg::ADR_MATCH, 32'h5);
      foreach (modes[i])
      begin
         arm({22'h0, 6'h28, modes[i]});
         check(32'(ccp_out_o), 32'h0);
         n = 0;
         while (adc_trigger_o !== 1'b1 && n < 100)
         begin
            @(posedge clk_i);
            n++;
         end
         check(32'(adc_trigger_o), 32'h1);
         check(32'(ccp_out_o), 32'(modes[i] != 4'h9));
         @(posedge clk_i);
         check(32'(compare_timer_clear_o), 32'(modes[i] == 4'h1 || modes[i] == 4'hb));
         check(32'(ccp_out_o), 32'(modes[i] < 4'ha && modes[i] != 4'h9));
         wb(1'b0, ccp_pkg::ADR_STATUS, 32'h0);
         check(32'(q[0]), 32'h1);
      end
      $display("compare modes done");
      // Match moved away after the trigger edge, before the timer clear edge
      arm(32'h281);
      while (compare_counter_i !== 16'h4)
         @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      wb(1'b1, ccp_pkg::ADR_MATCH, 32'h6);
      @(posedge clk_i);
      check(32'(compare_timer_clear_o), 32'h0);
      wb(1'b0, ccp_pkg::ADR_STATUS, 32'h0);
      check(32'(q[0]), 32'h1);
      $display("vanished match case done");
      foreach (inh[i])
      begin
         arm(32'h388);
         {compare_sync_i, sleep_i, compare_clock_alive_i} <= inh[i];
         repeat (40) @(posedge clk_i);
         check(32'(wake_o), 32'(inh[i] == 3'b111));
         {compare_sync_i, sleep_i, compare_clock_alive_i} <= 3'b100;
         wb(1'b0, ccp_pkg::ADR_STATUS, 32'h0);
         check(32'(q[0]), 32'(inh[i] == 3'b111));
      end
      $display("compare inhibit cases done");
      foreach (pwm[i])
      begin
         wb(1'b1, ccp_pkg::ADR_TIMER, 32'h0);
         wb(1'b1, ccp_pkg::ADR_PERIOD, {24'h0, pwm[i].p});
         wb(1'b1, ccp_pkg::ADR_CTRL, {24'h0, 1'b1, 2'b00, pwm[i].al, 4'hf});
         wb(1'b1, ccp_pkg::ADR_MATCH, {16'h0, pwm[i].m});
         wb(1'b1, ccp_pkg::ADR_STATUS, 32'h2);
         wb(1'b1, ccp_pkg::ADR_TIMER, {29'h0, pwm[i].ps, 1'b1});
         do
            wb(1'b0, ccp_pkg::ADR_STATUS, 32'h0);
         while (q[1] !== 1'b1);
         while (ccp_out_o !== 1'b0)
            @(posedge clk_i);
         while (ccp_out_o !== 1'b1)
            @(posedge clk_i);
         hi = 0;
         while (ccp_out_o === 1'b1)
         begin
            @(posedge clk_i);
            hi++;
         end
         per = hi;
         while (ccp_out_o !== 1'b1)
         begin
            @(posedge clk_i);
            per++;
         end
         check(32'(hi), 32'(pwm[i].hi));
         check(32'(per), 32'(pwm[i].per));
      end
      $display("pwm rows done");
      wb(1'b1, ccp_pkg::ADR_PERIOD, 32'h0);
      wb(1'b1, ccp_pkg::ADR_MATCH, 32'h0);
      repeat (1100) @(posedge clk_i);
      count_high(k);
      check(32'(k), 32'h0);
      wb(1'b1, ccp_pkg::ADR_MATCH, 32'h5);
      repeat (12) @(posedge clk_i);
      count_high(k);
      check(32'(k), 32'h8);
      wb(1'b1, ccp_pkg::ADR_PERIOD, 32'h3);
      wb(1'b1, ccp_pkg::ADR_CTRL, 32'h18f);
      repeat (40) @(posedge clk_i);
      sleep_i <= 1'b1;
      @(posedge clk_i);
      v = ccp_out_o;
      wb(1'b0, ccp_pkg::ADR_COUNT, 32'h0);
      c0 = q;
      repeat (30) @(posedge clk_i);
      wb(1'b0, ccp_pkg::ADR_COUNT, 32'h0);
      check(q, c0);
      check(32'(ccp_out_o), 32'(v));
      check(32'(wake_o), 32'h1);
      sleep_i <= 1'b0;
      $display("pwm edge cases done");
      reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      check(32'(ccp_out_o), 32'h0);
      wb(1'b0, ccp_pkg::ADR_PERIOD, 32'h0);
      check(q, 32'hff);
      $display("reset case done");
      final_report();
   end
endmodule : tb_top
